// ### include/mqaf_map.svh
`ifndef MQAF_MAP_SVH
`define MQAF_MAP_SVH
// Queue address layout: top bits carry the device identity, low bits the queue
`define MQAF_ADDR_W 8
`define MQAF_QIDX_W 3
`define MQAF_NUM_Q 8
`define MQAF_ID_W 3
`define MQAF_ID_MSB 7
// Words held by each queue, and the counter width that covers 0..depth
`define MQAF_DEPTH 9'h100
`define MQAF_CNT_W 9
// Preset almost-full offsets for default programming
`define MQAF_AF_OFS_LO 9'h008
`define MQAF_AF_OFS_HI 9'h080
// Write-side pipeline: almost-full follows the new queue at edge 3, full at edge 4
`define MQAF_WSEL_AF_EDGE 3
`define MQAF_WSEL_FF_EDGE 4
// Read-side pipeline: first word of the new queue lands at edge 3
`define MQAF_RSEL_OR_EDGE 3
// Controller wait after a selection before it may act on the new queue
`define MQAF_WSEL_WAIT 3'h3
`define MQAF_RSEL_WAIT 3'h3
`endif

// ### include/mqaf_pkg.sv
`include "mqaf_map.svh"
package mqaf_pkg;
  // Full queue address: identity bits over queue index
  typedef logic [`MQAF_ADDR_W-1:0] mqaf_addr_t;
  // Per-queue word count
  typedef logic [`MQAF_CNT_W-1:0] mqaf_cnt_t;
  // Controller port sequencing
  typedef enum logic [1:0] {
    MQAF_IDLE,
    MQAF_SWITCH,
    MQAF_READY
  } mqaf_port_e;
endpackage

// ### include/mqaf_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "mqaf_map.svh"
interface mqaf_if;
  // Write port
  logic [`MQAF_ADDR_W-1:0] write_queue_addr;
  logic                    write_addr_enable;
  logic                    write_en_n;
  // Read port
  logic [`MQAF_ADDR_W-1:0] read_queue_addr;
  logic                    read_addr_enable;
  logic                    read_en_n;
  // Shared flags; full and empty each with its output enable, almost-full flag and status bus without one
  logic                    full_flag_o;
  logic                    full_flag_oe;
  logic                    empty_flag_o;
  logic                    empty_flag_oe;
  logic                    almost_full_flag_n;
  logic [7:0]              almost_full_status_bus;
  // Wire levels, pulled high when nobody drives
  logic                    full_flag_n;
  logic                    empty_flag_n;
  assign full_flag_n  = full_flag_oe ? full_flag_o : 1'b1;
  assign empty_flag_n = empty_flag_oe ? empty_flag_o : 1'b1;
  modport device (
    input  write_queue_addr, write_addr_enable, write_en_n,
    input  read_queue_addr, read_addr_enable, read_en_n,
    output full_flag_o, full_flag_oe, empty_flag_o, empty_flag_oe,
    output almost_full_flag_n, almost_full_status_bus
  );
  modport ctrl (
    output write_queue_addr, write_addr_enable, write_en_n,
    output read_queue_addr, read_addr_enable, read_en_n,
    input  full_flag_n, empty_flag_n, almost_full_flag_n, almost_full_status_bus
  );
endinterface
`default_nettype wire

// ### design/mqaf_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "mqaf_map.svh"
module mqaf_ctrl (
  // Clock, reset, enable
  input  wire logic                    core_clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  // Link to the devices
  mqaf_if.ctrl                         lnk,
  // User write side
  input  wire logic                    usr_wsel,
  input  wire logic [`MQAF_ADDR_W-1:0] usr_wsel_addr,
  input  wire logic                    usr_wr,
  output logic                         usr_wr_done,
  // User read side
  input  wire logic                    usr_rsel,
  input  wire logic [`MQAF_ADDR_W-1:0] usr_rsel_addr,
  input  wire logic                    usr_rd,
  output logic                         usr_rd_done,
  // Port state
  output logic                         usr_wbusy,
  output logic                         usr_rbusy
);
  mqaf_pkg::mqaf_port_e wst_r;   // Write port sequencing
  mqaf_pkg::mqaf_port_e rst_r;   // Read port sequencing
  logic [2:0]           wwait_r; // Cycles left before the new write queue is usable
  logic [2:0]           rwait_r; // Cycles left before the new read queue shows
  logic                 wen_n_r; // Registered write strobe
  logic                 ren_n_r; // Registered read strobe
  logic                 wsel_r;  // Registered write selection strobe
  logic                 rsel_r;  // Registered read selection strobe
  logic [`MQAF_ADDR_W-1:0] waddr_r;
  logic [`MQAF_ADDR_W-1:0] raddr_r;

  // Link outputs come from flip-flops only
  assign lnk.write_queue_addr  = waddr_r;
  assign lnk.write_addr_enable = wsel_r;
  assign lnk.write_en_n        = wen_n_r;
  assign lnk.read_queue_addr   = raddr_r;
  assign lnk.read_addr_enable  = rsel_r;
  assign lnk.read_en_n         = ren_n_r;
  assign usr_wbusy             = wst_r != mqaf_pkg::MQAF_READY;
  assign usr_rbusy             = rst_r != mqaf_pkg::MQAF_READY;

  // Write port: one queue, hence one device, at a time; the single shared full
  // line is the only full status watched
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wst_r       <= mqaf_pkg::MQAF_IDLE;
      wwait_r     <= 3'h0;
      wen_n_r     <= 1'b1;
      wsel_r      <= 1'b0;
      waddr_r     <= 8'h00;
      usr_wr_done <= 1'b0;
    end else if (ce) begin
      wsel_r      <= 1'b0;
      wen_n_r     <= 1'b1;
      usr_wr_done <= 1'b0;
      unique case (wst_r)
        mqaf_pkg::MQAF_IDLE, mqaf_pkg::MQAF_READY: begin
          if (usr_wsel) begin
            // A selection never shares a cycle with a write
            wsel_r  <= 1'b1;
            waddr_r <= usr_wsel_addr;
            wwait_r <= `MQAF_WSEL_WAIT;
            wst_r   <= mqaf_pkg::MQAF_SWITCH;
          end else if (wst_r == mqaf_pkg::MQAF_READY && usr_wr && lnk.full_flag_n) begin
            wen_n_r     <= 1'b0;
            usr_wr_done <= 1'b1;
          end
        end
        mqaf_pkg::MQAF_SWITCH: begin
          // Full flag is valid for the new queue one edge before writes land
          if (wwait_r == 3'h1) begin
            wst_r <= mqaf_pkg::MQAF_READY;
          end
          wwait_r <= wwait_r - 3'h1;
        end
      endcase
    end
  end

  // Read port: one device at a time, shared empty line reports it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_r       <= mqaf_pkg::MQAF_IDLE;
      rwait_r     <= 3'h0;
      ren_n_r     <= 1'b1;
      rsel_r      <= 1'b0;
      raddr_r     <= 8'h00;
      usr_rd_done <= 1'b0;
    end else if (ce) begin
      rsel_r      <= 1'b0;
      ren_n_r     <= 1'b1;
      usr_rd_done <= 1'b0;
      unique case (rst_r)
        mqaf_pkg::MQAF_IDLE, mqaf_pkg::MQAF_READY: begin
          if (usr_rsel) begin
            rsel_r  <= 1'b1;
            raddr_r <= usr_rsel_addr;
            rwait_r <= `MQAF_RSEL_WAIT;
            rst_r   <= mqaf_pkg::MQAF_SWITCH;
          end else if (rst_r == mqaf_pkg::MQAF_READY && usr_rd && !lnk.empty_flag_n) begin
            // Output register holds a valid word: consume it
            ren_n_r     <= 1'b0;
            usr_rd_done <= 1'b1;
          end
        end
        mqaf_pkg::MQAF_SWITCH: begin
          if (rwait_r == 3'h1) begin
            rst_r <= mqaf_pkg::MQAF_READY;
          end
          rwait_r <= rwait_r - 3'h1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### design/mqaf_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "mqaf_map.svh"
// Notes on behaviour
// - Controller watches one shared full line
// - Controller writes one device at a time
// - Full flag floats when no own queue selected
// - Drive full when top address bits match identity
// - Identity width one to three bits
// - Same device keeps driving, flag follows queue
// - Controller reads one device, shared empty line
// - Empty flag floats when no own queue selected
// - Drive empty when top three bits match
// - Output-ready updates with each loaded word
// - Last word read: not ready next read
// - Queue switch: new status at third edge
// - Track all queue empties, change on edges
// - Almost-full shows only the write queue
// - Per-queue almost-full offset, zero to depth
// - Default offsets eight or 128 words
// - Almost-full follows new queue at third edge
// - Write crossing boundary: flag low two later
// - Read leaving almost-full: flag high two later
// - Skew violation adds one write cycle; not modelled here, since one clock drives both ports
// - Almost-full changes on edges, tracks reads
// - Copy every queue status on status bus
// - Full shows new queue at fourth edge
module mqaf_device (
  // Clock, reset, enable
  input  wire logic                    core_clk,
  input  wire logic                    srst,
  input  wire logic                    ce,
  // Link to the controller
  mqaf_if.device                       lnk,
  // Static identity and its width (1 to 3 bits compared on the write side)
  input  wire logic                    device_id_bit0,
  input  wire logic                    device_id_bit1,
  input  wire logic                    device_id_bit2,
  input  wire logic [1:0]              id_bits,
  // Almost-full offset programming
  input  wire logic                    af_default_hi,
  input  wire logic                    af_prog_we,
  input  wire logic [`MQAF_QIDX_W-1:0] af_prog_queue,
  input  wire logic [`MQAF_CNT_W-1:0]  af_prog_offset,
  // Output register status, local view
  output logic                         out_valid,
  output logic [`MQAF_QIDX_W-1:0]      out_queue
);
  mqaf_pkg::mqaf_cnt_t cnt_r [`MQAF_NUM_Q];  // Words held per queue
  mqaf_pkg::mqaf_cnt_t ofs_r [`MQAF_NUM_Q];  // Almost-full offset per queue
  mqaf_pkg::mqaf_addr_t wa1_r, wa2_r, wa3_r; // Write selection pipeline
  mqaf_pkg::mqaf_addr_t ra1_r, ra2_r;        // Read selection pipeline
  logic wsel1_r, wsel2_r, wsel3_r;           // Write selection markers
  logic rsel1_r, rsel2_r;                    // Read selection markers
  logic [`MQAF_NUM_Q-1:0] af_s1_r;           // First almost-full stage, all queues
  logic [`MQAF_NUM_Q-1:0] af_s2_r;           // Second stage feeds the status bus
  logic af_act_s1_r;                         // First stage of the active flag
  logic af_act_r;                            // Active almost-full flag, low = almost full
  logic ff_r, ff_oe_r, ef_oe_r;              // Full flag, its enable, empty enable
  logic ov_r;                                // Output register holds a valid word
  logic [`MQAF_QIDX_W-1:0] oq_r;             // Queue the output word came from
  logic [`MQAF_ID_W-1:0]   dev_id;           // Identity straps as a word
  logic                    wr_ok, rd_ld;     // Write and output-register load this cycle
  logic [`MQAF_QIDX_W-1:0] wq, rq;           // Queue indexes behind the pipelines
  logic                    preset_done_r;    // Preset offsets already applied

  assign dev_id = {device_id_bit2, device_id_bit1, device_id_bit0};
  assign wq     = wa3_r[`MQAF_QIDX_W-1:0];
  assign rq     = ra2_r[`MQAF_QIDX_W-1:0];

  // Full when the queue holds its whole depth
  function automatic logic is_full(input mqaf_pkg::mqaf_cnt_t c);
    is_full = c == `MQAF_DEPTH;
  endfunction

  // Almost full when free space has shrunk to the offset or below
  function automatic logic is_af(input mqaf_pkg::mqaf_cnt_t c, input mqaf_pkg::mqaf_cnt_t o);
    is_af = (`MQAF_DEPTH - c) <= o;
  endfunction

  // Compare the top n address bits with the low n identity bits
  function automatic logic id_match(input mqaf_pkg::mqaf_addr_t a,
                                    input logic [`MQAF_ID_W-1:0] id,
                                    input logic [1:0] n);
    unique case (n)
      2'h1: id_match = a[`MQAF_ID_MSB] == id[0];
      2'h2: id_match = a[`MQAF_ID_MSB -: 2] == id[1:0];
      2'h3: id_match = a[`MQAF_ID_MSB -: 3] == id;
      default: id_match = 1'b1; // No expansion: this device owns every address
    endcase
  endfunction

  // Writes land only on a non-full queue, from the fifth edge after selection
  assign wr_ok = !lnk.write_en_n && !is_full(cnt_r[wq]) && !wsel3_r
               && id_match(wa3_r, dev_id, id_bits);
  // Output register loads when empty or consumed, and the queue has a word;
  // a pending switch forces a load from the new queue instead
  assign rd_ld = (rsel2_r || !ov_r || !lnk.read_en_n) && (cnt_r[rq] != 9'h000)
               && ef_oe_r;

  // Selection pipelines: the captured address rules both enables until the
  // next selection, so a stray address between selections has no effect
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wa1_r   <= 8'h00;
      wa2_r   <= 8'h00;
      wa3_r   <= 8'h00;
      ra1_r   <= 8'h00;
      ra2_r   <= 8'h00;
      wsel1_r <= 1'b0;
      wsel2_r <= 1'b0;
      wsel3_r <= 1'b0;
      rsel1_r <= 1'b0;
      rsel2_r <= 1'b0;
    end else if (ce) begin
      if (lnk.write_addr_enable) begin
        wa1_r <= lnk.write_queue_addr;
      end
      wa2_r   <= wa1_r;
      wa3_r   <= wa2_r;
      wsel1_r <= lnk.write_addr_enable;
      wsel2_r <= wsel1_r;
      wsel3_r <= wsel2_r;
      if (lnk.read_addr_enable) begin
        ra1_r <= lnk.read_queue_addr;
      end
      ra2_r   <= ra1_r;
      rsel1_r <= lnk.read_addr_enable;
      rsel2_r <= rsel1_r;
    end
  end

  // Word counts of every queue follow writes and loads, active or not
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < `MQAF_NUM_Q; i++) begin
        cnt_r[i] <= 9'h000;
      end
    end else if (ce) begin
      for (int i = 0; i < `MQAF_NUM_Q; i++) begin
        // A write and a load on one queue in one cycle cancel out
        if (wr_ok && wq == i[`MQAF_QIDX_W-1:0] && !(rd_ld && rq == i[`MQAF_QIDX_W-1:0])) begin
          cnt_r[i] <= cnt_r[i] + 9'h001;
        end else if (rd_ld && rq == i[`MQAF_QIDX_W-1:0]
                     && !(wr_ok && wq == i[`MQAF_QIDX_W-1:0])) begin
          cnt_r[i] <= cnt_r[i] - 9'h001;
        end
      end
    end
  end

  // Offsets: the preset lands on the first enabled edge after reset, then
  // per-queue programming, clamped to depth
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < `MQAF_NUM_Q; i++) begin
        ofs_r[i] <= `MQAF_AF_OFS_LO;
      end
    end else if (ce) begin
      if (!preset_done_r) begin
        // Preset wins over programming on that single edge
        for (int i = 0; i < `MQAF_NUM_Q; i++) begin
          ofs_r[i] <= af_default_hi ? `MQAF_AF_OFS_HI : `MQAF_AF_OFS_LO;
        end
      end else if (af_prog_we) begin
        ofs_r[af_prog_queue] <= (af_prog_offset > `MQAF_DEPTH) ? `MQAF_DEPTH
                                                              : af_prog_offset;
      end
    end
  end

  // Preset choice is caught on the first enabled edge after reset release,
  // since a synchronous reset may only load constants
  always_ff @(posedge core_clk) begin
    if (srst) begin
      preset_done_r <= 1'b0;
    end else if (ce) begin
      preset_done_r <= 1'b1;
    end
  end

  // Almost-full: two register stages for every queue and for the active one
  always_ff @(posedge core_clk) begin
    if (srst) begin
      af_s1_r     <= 8'h00;
      af_s2_r     <= 8'h00;
      af_act_s1_r <= 1'b0;
      af_act_r    <= 1'b1;
    end else if (ce) begin
      for (int i = 0; i < `MQAF_NUM_Q; i++) begin
        af_s1_r[i] <= is_af(cnt_r[i], ofs_r[i]);
      end
      af_s2_r <= af_s1_r;
      // The first stage already looks at the queue captured one edge ago, so
      // the flag shows the new queue on the third edge
      af_act_s1_r <= is_af(cnt_r[wa1_r[`MQAF_QIDX_W-1:0]], ofs_r[wa1_r[`MQAF_QIDX_W-1:0]]);
      // Count change at edge k reaches the pin at edge k+2
      // One clock drives both ports, so the skew penalty never arises
      af_act_r <= !af_act_s1_r;
    end
  end

  // Full flag and its enable switch together, at the fourth edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ff_r    <= 1'b1;
      ff_oe_r <= 1'b0;
    end else if (ce) begin
      ff_r    <= !is_full(cnt_r[wq]);
      ff_oe_r <= id_match(wa3_r, dev_id, id_bits);
    end
  end

  // Output register state and the empty enable
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ov_r    <= 1'b0;
      oq_r    <= 3'h0;
      ef_oe_r <= 1'b0;
    end else if (ce) begin
      ef_oe_r <= ra1_r[`MQAF_ID_MSB -: 3] == dev_id;
      if (rd_ld) begin
        ov_r <= 1'b1;
        oq_r <= rq;
      end else if (rsel2_r) begin
        ov_r <= 1'b0;
        oq_r <= rq;
      end else if (!lnk.read_en_n) begin
        ov_r <= 1'b0;
      end
    end
  end

  assign lnk.full_flag_o            = ff_r;
  assign lnk.full_flag_oe           = ff_oe_r;
  assign lnk.empty_flag_o           = !ov_r;
  assign lnk.empty_flag_oe          = ef_oe_r;
  assign lnk.almost_full_flag_n     = af_act_r;
  assign lnk.almost_full_status_bus = ~af_s2_r;
  assign out_valid                  = ov_r;
  assign out_queue                  = oq_r;
endmodule
`default_nettype wire

// ### tb/mqaf_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module mqaf_chk_sva #(
  parameter logic [2:0] DEV_ID = 3'h5 // Identity strapped on the watched end
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       srst,
  // Write port
  input wire logic [7:0] write_queue_addr,
  input wire logic       write_addr_enable,
  input wire logic       write_en_n,
  // Read port
  input wire logic [7:0] read_queue_addr,
  input wire logic       read_addr_enable,
  input wire logic       read_en_n,
  // Flags from the device end
  input wire logic       full_flag_oe,
  input wire logic       empty_flag_oe,
  input wire logic       empty_flag_o,
  input wire logic       almost_full_flag_n,
  input wire logic [7:0] almost_full_status_bus
);
  logic [2:0] wage_r; // Edges since the last write selection, saturating
  logic [2:0] rage_r; // Edges since the last read selection, saturating
  logic [7:0] wa_r;   // Write address taken at the last selection
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Ages saturate so long idle stretches never wrap back into the window
  always_ff @(posedge core_clk) begin
    if (srst || write_addr_enable) wage_r <= 3'h0;
    else if (wage_r != 3'h7) wage_r <= wage_r + 3'h1;
  end
  always_ff @(posedge core_clk) begin
    if (srst || read_addr_enable) rage_r <= 3'h0;
    else if (rage_r != 3'h7) rage_r <= rage_r + 3'h1;
  end
  // Captured address, zero after reset like the device's own copy
  always_ff @(posedge core_clk) begin
    if (srst) wa_r <= 8'h00;
    else if (write_addr_enable) wa_r <= write_queue_addr;
  end
  property p_ff_float;
    write_addr_enable && write_queue_addr[7:5] != DEV_ID ##1 !write_addr_enable [*4]
      |-> !full_flag_oe;
  endproperty
  a_ff_float: assert property (p_ff_float) else $error("full flag driven for foreign queue");
  property p_ff_drive;
    write_addr_enable && write_queue_addr[7:5] == DEV_ID ##1 !write_addr_enable [*4]
      |-> full_flag_oe;
  endproperty
  a_ff_drive: assert property (p_ff_drive) else $error("full flag not driven for own queue");
  property p_ef_float;
    read_addr_enable && read_queue_addr[7:5] != DEV_ID ##1 !read_addr_enable [*2]
      |-> !empty_flag_oe;
  endproperty
  a_ef_float: assert property (p_ef_float) else $error("empty flag driven for foreign queue");
  property p_ef_drive;
    read_addr_enable && read_queue_addr[7:5] == DEV_ID ##1 !read_addr_enable [*2]
      |-> empty_flag_oe;
  endproperty
  a_ef_drive: assert property (p_ef_drive) else $error("empty flag not driven for own queue");
  property p_ff_steady;
    $changed(full_flag_oe) |-> wage_r <= 3'h4;
  endproperty
  a_ff_steady: assert property (p_ff_steady) else $error("full enable moved without selection");
  property p_ef_steady;
    $changed(empty_flag_oe) |-> rage_r <= 3'h2;
  endproperty
  a_ef_steady: assert property (p_ef_steady) else $error("empty enable moved without selection");
  property p_af_copy;
    wage_r >= 3'h4 && wa_r[7:5] == DEV_ID
      |-> almost_full_flag_n == almost_full_status_bus[wa_r[2:0]];
  endproperty
  a_af_copy: assert property (p_af_copy) else $error("almost-full flag differs from bus copy");
  property p_or_hold;
    read_addr_enable && read_en_n && write_en_n |=> $stable(empty_flag_o);
  endproperty
  a_or_hold: assert property (p_or_hold) else $error("ready flag moved before new queue");
  property p_af_fall;
    $fell(almost_full_flag_n) |-> !$past(write_en_n, 2) || !$past(write_en_n, 3) || wage_r <= 3'h3;
  endproperty
  a_af_fall: assert property (p_af_fall) else $error("almost-full fell with no write");
endmodule
`default_nettype wire

// ### tb/multiqueue_active_flags_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "mqaf_map.svh"
module multiqueue_active_flags_tb;
  logic       core_clk, srst, ce;         // Clock, reset, enable
  logic       usr_wsel, usr_wr, usr_rsel; // User strobes
  logic       usr_rd, af_prog_we, af_default_hi;
  logic [7:0] usr_wsel_addr, usr_rsel_addr; // Queue selections
  logic [2:0] af_prog_queue;              // Offset programming
  logic [8:0] af_prog_offset;
  logic       usr_wr_done, usr_rd_done;   // Outputs seen
  logic       usr_wbusy, usr_rbusy, out_valid;
  logic [2:0] out_queue;
  int         miscompares, tests_run;     // Report counters
  mqaf_if lnk ();
  mqaf_ctrl mqaf_ctrl_inst (.core_clk(core_clk), .srst(srst), .ce(ce), .lnk(lnk),
    .usr_wsel(usr_wsel), .usr_wsel_addr(usr_wsel_addr), .usr_wr(usr_wr),
    .usr_wr_done(usr_wr_done), .usr_rsel(usr_rsel), .usr_rsel_addr(usr_rsel_addr),
    .usr_rd(usr_rd), .usr_rd_done(usr_rd_done), .usr_wbusy(usr_wbusy), .usr_rbusy(usr_rbusy));
  // Identity 5 so that reset's captured address 0 does not select this end
  mqaf_device mqaf_device_inst (.core_clk(core_clk), .srst(srst), .ce(ce), .lnk(lnk),
    .device_id_bit0(1'b1), .device_id_bit1(1'b0), .device_id_bit2(1'b1), .id_bits(2'h3),
    .af_default_hi(af_default_hi), .af_prog_we(af_prog_we), .af_prog_queue(af_prog_queue),
    .af_prog_offset(af_prog_offset), .out_valid(out_valid), .out_queue(out_queue));
  mqaf_chk_sva #(.DEV_ID(3'h5)) mqaf_chk_sva_inst (.core_clk(core_clk), .srst(srst),
    .write_queue_addr(lnk.write_queue_addr), .write_addr_enable(lnk.write_addr_enable),
    .write_en_n(lnk.write_en_n), .read_queue_addr(lnk.read_queue_addr),
    .read_addr_enable(lnk.read_addr_enable), .read_en_n(lnk.read_en_n),
    .full_flag_oe(lnk.full_flag_oe), .empty_flag_oe(lnk.empty_flag_oe),
    .empty_flag_o(lnk.empty_flag_o), .almost_full_flag_n(lnk.almost_full_flag_n),
    .almost_full_status_bus(lnk.almost_full_status_bus));
  // Free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Byte compare, four-state exact
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Single flag compare
  task automatic chk1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait at falling edges; a hang ends the run
  task automatic wait_lvl(ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl) begin
      @(negedge core_clk);
      n++;
      if (n > 50) begin
        miscompares++;
        $display("Error wait expected %b seen %b", lvl, sig);
        close_out();
      end
    end
  endtask
  // Select a write queue and wait until the port may write
  task automatic wsel(input logic [7:0] a);
    usr_wsel = 1'b1;
    usr_wsel_addr = a;
    @(negedge core_clk);
    usr_wsel = 1'b0;
    @(negedge core_clk);
    wait_lvl(usr_wbusy, 1'b0);
    @(negedge core_clk);
  endtask
  // Select a read queue and wait past the output-register reload
  task automatic rsel(input logic [7:0] a);
    usr_rsel = 1'b1;
    usr_rsel_addr = a;
    @(negedge core_clk);
    usr_rsel = 1'b0;
    @(negedge core_clk);
    wait_lvl(usr_rbusy, 1'b0);
    @(negedge core_clk);
  endtask
  // Request held until the strobe is reported issued
  task automatic wr1();
    usr_wr = 1'b1;
    wait_lvl(usr_wr_done, 1'b1);
    usr_wr = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic rd1();
    usr_rd = 1'b1;
    wait_lvl(usr_rd_done, 1'b1);
    usr_rd = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  // Reset leaves all queues empty and both shared flags released
  task automatic sc_reset();
    chk("status_bus", 8'hff, lnk.almost_full_status_bus);
    chk1("af_flag", 1'b1, lnk.almost_full_flag_n);
    chk1("ff_oe", 1'b0, lnk.full_flag_oe);
    chk1("ef_oe", 1'b0, lnk.empty_flag_oe);
  endtask
  // Queues of another identity leave the wires to the pull-ups
  task automatic sc_float();
    wsel(8'he1);
    rsel(8'h21);
    chk1("ff_oe", 1'b0, lnk.full_flag_oe);
    chk1("ff_wire", 1'b1, lnk.full_flag_n);
    chk1("ef_oe", 1'b0, lnk.empty_flag_oe);
    chk1("ef_wire", 1'b1, lnk.empty_flag_n);
  endtask
  // Own queues take both wires; an empty read queue reports not ready
  task automatic sc_drive();
    wsel(8'ha1);
    rsel(8'ha2);
    chk1("ff_oe", 1'b1, lnk.full_flag_oe);
    chk1("ff_wire", 1'b1, lnk.full_flag_n);
    chk1("ef_oe", 1'b1, lnk.empty_flag_oe);
    chk1("ef_wire", 1'b1, lnk.empty_flag_n);
  endtask
  // Offset of depth-1 makes one word cross the boundary
  task automatic sc_af();
    af_prog_queue = 3'h1;
    af_prog_offset = `MQAF_DEPTH - 9'h001;
    af_prog_we = 1'b1;
    @(negedge core_clk);
    af_prog_we = 1'b0;
    wr1();
    chk1("af_flag", 1'b0, lnk.almost_full_flag_n);
    chk("status_bus", 8'hfd, lnk.almost_full_status_bus);
    wsel(8'ha2);
    chk1("af_flag", 1'b1, lnk.almost_full_flag_n);
    chk1("ff_oe", 1'b1, lnk.full_flag_oe);
    chk("status_bus", 8'hfd, lnk.almost_full_status_bus);
  endtask
  // Drain the almost-full write queue through the read port, then see a
  // write into another queue turn up after a switch; low flag = ready
  task automatic sc_read();
    wsel(8'ha1);
    chk1("af_flag", 1'b0, lnk.almost_full_flag_n);
    rsel(8'ha1);
    chk1("ef_wire", 1'b0, lnk.empty_flag_n);
    chk1("out_valid", 1'b1, out_valid);
    chk("out_queue", 8'h01, {5'h00, out_queue});
    // Flag and bus copy trail the load by two edges
    @(negedge core_clk);
    chk("status_bus", 8'hff, lnk.almost_full_status_bus);
    chk1("af_flag", 1'b1, lnk.almost_full_flag_n);
    rd1();
    chk1("ef_wire", 1'b1, lnk.empty_flag_n);
    wsel(8'ha2);
    wr1();
    rsel(8'ha2);
    chk1("ef_wire", 1'b0, lnk.empty_flag_n);
  endtask
  // Mid-run reset with the high preset: the 128th word reaches the boundary
  task automatic sc_preset();
    srst = 1'b1;
    af_default_hi = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    wsel(8'ha3);
    repeat (127) wr1();
    chk1("af_flag", 1'b1, lnk.almost_full_flag_n);
    wr1();
    chk1("af_flag", 1'b0, lnk.almost_full_flag_n);
  endtask
  // Main sequence: inputs set at time zero, reset held 8 cycles
  initial begin
    miscompares = 0;
    tests_run = 0;
    srst = 1'b1;
    ce = 1'b1;
    usr_wsel = 1'b0;
    usr_wr = 1'b0;
    usr_rsel = 1'b0;
    usr_rd = 1'b0;
    af_prog_we = 1'b0;
    af_default_hi = 1'b0;
    usr_wsel_addr = 8'h00;
    usr_rsel_addr = 8'h00;
    af_prog_queue = 3'h0;
    af_prog_offset = 9'h000;
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    repeat (2) @(negedge core_clk);
    sc_reset();
    sc_float();
    sc_drive();
    sc_af();
    sc_read();
    sc_preset();
    close_out();
  end
endmodule
`default_nettype wire
